// ---- hw/smfr_regs.svh ----
`ifndef SMFR_REGS_SVH
`define SMFR_REGS_SVH

// Read command codes.
`define SMFR_OPC_QUICK 8'h0B
`define SMFR_OPC_DDR 8'h0D
`define SMFR_OPC_DOUT 8'h3B
`define SMFR_OPC_DIO 8'hBB

// Mode byte patterns that keep continuous read mode.
`define SMFR_MODE_NIB 4'hA
`define SMFR_MODE_DDR 8'hA5

// Field lengths in bits, counted against a 6-bit bit counter.
`define SMFR_OPC_BITS 6'h08
`define SMFR_ADDR_BITS 6'h18
`define SMFR_MODE_BITS 6'h08
`define SMFR_BYTE_BITS 6'h08

// Array address width and highest byte location.
`define SMFR_AW 19
`define SMFR_ADDR_TOP 19'h7_FFFF
`define SMFR_ADDR_ONE 19'h0_0001
`define SMFR_ADDR_ZERO 19'h0_0000

// Lanes carried per serial clock.
`define SMFR_W1 4'h1
`define SMFR_W2 4'h2
`define SMFR_W4 4'h4
`define SMFR_W8 4'h8

// Pin output enable masks.
`define SMFR_OE_NONE 4'h0
`define SMFR_OE_IO1 4'h2
`define SMFR_OE_DUAL 4'h3
`define SMFR_OE_QUAD 4'hF

`endif

// ---- hw/smfr_pkg.sv ----
package smfr_pkg;

    typedef enum logic [5:0] {
        SMFR_ST_OPC = 6'b00_0001,
        SMFR_ST_ADDR = 6'b00_0010,
        SMFR_ST_MODE = 6'b00_0100,
        SMFR_ST_DUMMY = 6'b00_1000,
        SMFR_ST_DATA = 6'b01_0000,
        SMFR_ST_IGNORE = 6'b10_0000
    } smfr_state_t;

    typedef enum logic [4:0] {
        SMFR_CMD_NONE = 5'b0_0001,
        SMFR_CMD_QUICK = 5'b0_0010,
        SMFR_CMD_DDR = 5'b0_0100,
        SMFR_CMD_DOUT = 5'b0_1000,
        SMFR_CMD_DIO = 5'b1_0000
    } smfr_cmd_t;

    // Configuration as seen by the link: latency code, dual, quad.
    typedef struct packed {
        logic [3:0] lat;
        logic dual;
        logic quad;
    } smfr_cfg_t;

    // System clock domain state.
    typedef struct packed {
        smfr_cfg_t cfg;
        logic xip_s1;
        logic xip_s2;
        logic cs_s1;
        logic cs_s2;
        logic active;
        logic lrst;
        logic lack_s1;
        logic lack_s2;
    } smfr_sys_t;

    // Link state that survives chip select.
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        smfr_cfg_t cfg_s1;
        smfr_cfg_t cfg_s2;
        logic xip_on;
        smfr_cmd_t xip_cmd;
    } smfr_keep_t;

    // Link state that lives for one frame.
    typedef struct packed {
        smfr_state_t state;
        smfr_cmd_t cmd;
        logic first;
        logic [5:0] cnt;
        logic [3:0] dcnt;
        logic [23:0] sh;
        logic [18:0] addr;
        logic [7:0] dsh;
        logic [3:0] lo;
    } smfr_frame_t;

    // Falling edge state: input sample and pin drive.
    typedef struct packed {
        logic [3:0] smp;
        logic [3:0] out;
        logic [3:0] oe;
    } smfr_neg_t;

endpackage : smfr_pkg

// ---- hw/smfr_read_seq.sv ----
// Contract
// - Quick read accepted in all three protocols.
// - Read starts at any addressed byte.
// - Address advances by one per byte.
// - Address wraps from top to zero.
// - Nibble A mode byte enters continuous mode.
// - Other mode byte leaves continuous mode.
// - Dummy clocks follow the latency code.
// - Double-edge read only in quad protocol.
// - Double-edge continuous needs exact A5 byte.
// - Two-line data drives after last dummy.
// - Two-line output read supports continuous mode.
// - Two-line address after single-line opcode.
// - Two-line data, bit seven on line one.
// - Two-line address read supports continuous mode.
// - Only nineteen address bits are decoded.
`timescale 1ns/1ps
`include "smfr_regs.svh"

module smfr_read_seq (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] latency_code_bits_i,
    input wire logic dual_protocol_mode_i,
    input wire logic quad_protocol_mode_i,
    output logic continuous_read_mode_o,
    output logic frame_active_o,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic [3:0] io_oe_o,
    output logic [18:0] mem_addr_o,
    input wire logic [7:0] mem_rdata_i
);
    import smfr_pkg::*;

    localparam smfr_frame_t FRAME_RST = '{
        state: SMFR_ST_OPC,
        cmd: SMFR_CMD_NONE,
        first: 1'b1,
        cnt: 6'h00,
        dcnt: 4'h0,
        sh: 24'h00_0000,
        addr: 19'h0_0000,
        dsh: 8'h00,
        lo: 4'h0
    };

    smfr_sys_t s_r;
    smfr_sys_t s_nxt;
    smfr_keep_t k_r;
    smfr_keep_t k_nxt;
    smfr_frame_t f_r;
    smfr_frame_t f_nxt;
    smfr_neg_t n_r;
    smfr_neg_t n_nxt;

    smfr_state_t st;
    smfr_cmd_t cmd;
    logic [3:0] proto_w;
    logic [3:0] w;
    logic [23:0] sh;
    logic [23:0] dsh_w;
    logic [5:0] cnt;
    logic [3:0] dnext;
    logic load;
    logic mode_end;
    logic mode_hit;

    // Lanes of the header: opcode and quick read follow the bus protocol.
    function automatic logic [3:0] proto_f(input smfr_cfg_t c);
        if (c.quad) begin
            return `SMFR_W4;
        end else if (c.dual) begin
            return `SMFR_W2;
        end
        return `SMFR_W1;
    endfunction : proto_f

    function automatic smfr_cmd_t decode_f(input logic [7:0] op,
                                           input logic [3:0] pw);
        case (op)
            `SMFR_OPC_QUICK: begin
                return SMFR_CMD_QUICK;
            end
            `SMFR_OPC_DDR: begin
                return (pw == `SMFR_W4) ? SMFR_CMD_DDR
                                        : SMFR_CMD_NONE;
            end
            `SMFR_OPC_DOUT: begin
                return (pw == `SMFR_W1) ? SMFR_CMD_DOUT : SMFR_CMD_NONE;
            end
            `SMFR_OPC_DIO: begin
                return (pw == `SMFR_W1) ? SMFR_CMD_DIO : SMFR_CMD_NONE;
            end
            default: begin
                return SMFR_CMD_NONE;
            end
        endcase
    endfunction : decode_f

    // Lanes per clock in each phase of each command.
    function automatic logic [3:0] lanes_f(input smfr_state_t s,
                                           input smfr_cmd_t c,
                                           input logic [3:0] pw);
        if (s == SMFR_ST_OPC) begin
            return pw;
        end
        case (c)
            SMFR_CMD_DDR: begin
                return `SMFR_W8;
            end
            SMFR_CMD_DOUT: begin
                return (s == SMFR_ST_DATA) ? `SMFR_W2 : `SMFR_W1;
            end
            SMFR_CMD_DIO: begin
                return `SMFR_W2;
            end
            default: begin
                return pw;
            end
        endcase
    endfunction : lanes_f

    function automatic logic [23:0] shift_f(input logic [23:0] v,
                                            input logic [3:0] lw,
                                            input logic [7:0] b);
        case (lw)
            `SMFR_W1: begin
                return {v[22:0], b[0]};
            end
            `SMFR_W2: begin
                return {v[21:0], b[1:0]};
            end
            `SMFR_W4: begin
                return {v[19:0], b[3:0]};
            end
            default: begin
                return {v[15:0], b};
            end
        endcase
    endfunction : shift_f

    // System clock side: configuration is registered here so that the
    // link samples a flop, and link status is brought back over two flops.
    always_comb begin
        s_nxt = s_r;
        s_nxt.cfg.lat = latency_code_bits_i;
        s_nxt.cfg.dual = dual_protocol_mode_i;
        s_nxt.cfg.quad = quad_protocol_mode_i;
        s_nxt.xip_s1 = k_r.xip_on;
        s_nxt.xip_s2 = s_r.xip_s1;
        s_nxt.cs_s1 = cs_n_i;
        s_nxt.cs_s2 = s_r.cs_s1;
        s_nxt.active = ~s_r.cs_s2;
        // The link reset is held here until the link reports it, because
        // a short reset may see no serial clock edge at all.
        s_nxt.lack_s1 = ~k_r.rst_s2;
        s_nxt.lack_s2 = s_r.lack_s1;
        if (s_r.lack_s2) begin
            s_nxt.lrst = 1'b0;
        end
        if (!rstn_i) begin
            s_nxt = '0;
            s_nxt.lrst = 1'b1;
            s_nxt.cs_s1 = 1'b1;
            s_nxt.cs_s2 = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign continuous_read_mode_o = s_r.xip_s2;
    assign frame_active_o = s_r.active;

    // Rising edge of the serial clock: header capture and byte stepping.
    always_comb begin
        f_nxt = f_r;
        k_nxt = k_r;
        f_nxt.first = 1'b0;
        load = 1'b0;
        mode_end = 1'b0;
        mode_hit = 1'b0;
        st = f_r.state;
        cmd = f_r.cmd;
        // A frame in continuous mode opens straight on the address.
        if (f_r.first && k_r.xip_on) begin
            st = SMFR_ST_ADDR;
            cmd = k_r.xip_cmd;
        end
        f_nxt.state = st;
        f_nxt.cmd = cmd;
        proto_w = proto_f(k_r.cfg_s2);
        w = lanes_f(st, cmd, proto_w);
        sh = shift_f(f_r.sh, w, {n_r.smp, io_i});
        dsh_w = shift_f({16'h0000, f_r.dsh}, w, 8'h00);
        cnt = f_r.cnt + {2'b00, w};
        dnext = f_r.dcnt + 4'h1;
        case (st)
            SMFR_ST_OPC: begin
                f_nxt.sh = sh;
                f_nxt.cnt = cnt;
                if (cnt == `SMFR_OPC_BITS) begin
                    f_nxt.cnt = 6'h00;
                    f_nxt.cmd = decode_f(sh[7:0], proto_w);
                    if (decode_f(sh[7:0], proto_w) == SMFR_CMD_NONE) begin
                        f_nxt.state = SMFR_ST_IGNORE;
                    end else begin
                        f_nxt.state = SMFR_ST_ADDR;
                    end
                end
            end
            SMFR_ST_ADDR: begin
                f_nxt.sh = sh;
                f_nxt.cnt = cnt;
                if (cnt == `SMFR_ADDR_BITS) begin
                    f_nxt.cnt = 6'h00;
                    // Upper address bits are don't care.
                    f_nxt.addr = sh[`SMFR_AW-1:0];
                    f_nxt.state = SMFR_ST_MODE;
                end
            end
            SMFR_ST_MODE: begin
                f_nxt.sh = sh;
                f_nxt.cnt = cnt;
                if (cnt == `SMFR_MODE_BITS) begin
                    f_nxt.cnt = 6'h00;
                    mode_end = 1'b1;
                    if (cmd == SMFR_CMD_DDR) begin
                        mode_hit = (sh[7:0] == `SMFR_MODE_DDR);
                    end else begin
                        mode_hit = (sh[7:4] == `SMFR_MODE_NIB);
                    end
                    f_nxt.dcnt = 4'h0;
                    if (k_r.cfg_s2.lat == 4'h0) begin
                        load = 1'b1;
                    end else begin
                        f_nxt.state = SMFR_ST_DUMMY;
                    end
                end
            end
            SMFR_ST_DUMMY: begin
                f_nxt.dcnt = dnext;
                if (dnext == k_r.cfg_s2.lat) begin
                    load = 1'b1;
                end
            end
            SMFR_ST_DATA: begin
                if (cmd == SMFR_CMD_DDR) begin
                    // Low nibble goes out on the high clock phase.
                    f_nxt.lo = f_r.dsh[3:0];
                    load = 1'b1;
                end else begin
                    f_nxt.dsh = dsh_w[7:0];
                    f_nxt.cnt = cnt;
                    if (cnt == `SMFR_BYTE_BITS) begin
                        load = 1'b1;
                    end
                end
            end
            SMFR_ST_IGNORE: begin
                f_nxt.state = SMFR_ST_IGNORE;
            end
            default: begin
                f_nxt.state = SMFR_ST_IGNORE;
            end
        endcase
        // The next byte is fetched as the previous one starts shifting,
        // so the array read never waits on the serial clock.
        if (load) begin
            f_nxt.state = SMFR_ST_DATA;
            f_nxt.dsh = mem_rdata_i;
            f_nxt.cnt = 6'h00;
            if (f_r.addr == `SMFR_ADDR_TOP) begin
                f_nxt.addr = `SMFR_ADDR_ZERO;
            end else begin
                f_nxt.addr = f_r.addr + `SMFR_ADDR_ONE;
            end
        end

        k_nxt.rst_s1 = ~s_r.lrst;
        k_nxt.rst_s2 = k_r.rst_s1;
        k_nxt.cfg_s1 = s_r.cfg;
        k_nxt.cfg_s2 = k_r.cfg_s1;
        if (!k_r.rst_s2) begin
            k_nxt.xip_on = 1'b0;
            k_nxt.xip_cmd = SMFR_CMD_NONE;
        end else if (mode_end) begin
            k_nxt.xip_on = mode_hit;
            k_nxt.xip_cmd = cmd;
        end
    end

    // Raising chip select ends the frame at once, even with the serial
    // clock stopped; continuous mode lives outside this reset.
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            f_r <= FRAME_RST;
        end else begin
            f_r <= f_nxt;
        end
    end

    always_ff @(posedge sck_i) begin
        k_r <= k_nxt;
    end

    // Falling edge: double-edge input sample and the pin drive.
    always_comb begin
        n_nxt.smp = io_i;
        n_nxt.out = 4'h0;
        n_nxt.oe = `SMFR_OE_NONE;
        if (f_r.state == SMFR_ST_DATA) begin
            case (f_r.cmd)
                SMFR_CMD_DDR: begin
                    n_nxt.out = f_r.dsh[7:4];
                    n_nxt.oe = `SMFR_OE_QUAD;
                end
                SMFR_CMD_DOUT, SMFR_CMD_DIO: begin
                    n_nxt.out = {2'b00, f_r.dsh[7:6]};
                    n_nxt.oe = `SMFR_OE_DUAL;
                end
                default: begin
                    if (proto_w == `SMFR_W4) begin
                        n_nxt.out = f_r.dsh[7:4];
                        n_nxt.oe = `SMFR_OE_QUAD;
                    end else if (proto_w == `SMFR_W2) begin
                        n_nxt.out = {2'b00, f_r.dsh[7:6]};
                        n_nxt.oe = `SMFR_OE_DUAL;
                    end else begin
                        n_nxt.out = {2'b00, f_r.dsh[7], 1'b0};
                        n_nxt.oe = `SMFR_OE_IO1;
                    end
                end
            endcase
        end
    end

    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            n_r <= '0;
        end else begin
            n_r <= n_nxt;
        end
    end

    // In double-edge data the pins carry the rising edge nibble while the
    // clock is high; this is the one place the drive passes a gate.
    assign io_o = (f_r.cmd == SMFR_CMD_DDR && f_r.state == SMFR_ST_DATA
                   && sck_i) ? f_r.lo : n_r.out;
    assign io_oe_o = n_r.oe;
    assign mem_addr_o = f_r.addr;

endmodule : smfr_read_seq

// ---- bench/smfr_read_seq_monitor.sv ----
`timescale 1ns/1ps
module smfr_read_seq_monitor (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic quad_protocol_mode_i,
    input wire logic continuous_read_mode_o,
    input wire logic frame_active_o,
    input wire logic cs_n_i,
    input wire logic [3:0] io_oe_o,
    input wire logic [18:0] mem_addr_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    // Idle time since a frame ended; zero until the first frame is seen.
    logic [3:0] idle_r;
    logic [3:0] idle_nxt;
    always_comb begin
        idle_nxt = idle_r;
        if (frame_active_o) begin
            idle_nxt = 4'h1;
        end else if (idle_r != 4'h0 && idle_r != 4'hF) begin
            idle_nxt = idle_r + 4'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            idle_r <= 4'h0;
        end else begin
            idle_r <= idle_nxt;
        end
    end
    a_oe_idle: assert property (cs_n_i |-> io_oe_o == 4'h0)
        else $error("pins driven while deselected");
    a_no_early: assert property ($fell(cs_n_i) |-> (io_oe_o == 4'h0) [*8])
        else $error("pins driven at frame start");
    a_lane_mask: assert property (!quad_protocol_mode_i
        |-> io_oe_o inside {4'h0, 4'h2, 4'h3})
        else $error("upper lanes driven outside quad");
    a_oe_stands: assert property (!cs_n_i && !$past(cs_n_i)
        && $past(io_oe_o) != 4'h0 |-> io_oe_o == $past(io_oe_o))
        else $error("drive dropped inside frame");
    a_addr_step: assert property (!cs_n_i && !$past(cs_n_i)
        && $past(io_oe_o) != 4'h0 && $changed(mem_addr_o)
        |-> mem_addr_o == $past(mem_addr_o) + 19'h0_0001)
        else $error("read address did not step by one");
    a_xip_idle: assert property (idle_r == 4'hF
        |-> $stable(continuous_read_mode_o))
        else $error("continuous mode changed while idle");
    a_frame_up: assert property ($fell(cs_n_i) |-> ##[1:5] frame_active_o)
        else $error("frame not seen");
    a_frame_down: assert property ($rose(cs_n_i) |-> ##[1:5] !frame_active_o)
        else $error("frame end not seen");
    a_reset_quiet: assert property ($rose(rstn_i)
        |-> !frame_active_o && !continuous_read_mode_o)
        else $error("status set after reset");
    c_xip_on: cover property (continuous_read_mode_o);
    c_two_lanes: cover property (io_oe_o == 4'h3);
    c_wrap: cover property ($past(mem_addr_o) == 19'h7_FFFF
        && mem_addr_o == 19'h0_0000);
endmodule : smfr_read_seq_monitor

bind smfr_read_seq smfr_read_seq_monitor mon_u (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .quad_protocol_mode_i(quad_protocol_mode_i),
    .continuous_read_mode_o(continuous_read_mode_o),
    .frame_active_o(frame_active_o), .cs_n_i(cs_n_i),
    .io_oe_o(io_oe_o), .mem_addr_o(mem_addr_o)
);

// ---- bench/smfr_host.sv ----
`timescale 1ns/1ps
module smfr_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic [3:0] hd_o,
    output logic [3:0] hoe_o,
    output logic flt_o,
    input wire logic [3:0] pin_i
);
    localparam real HALF = 62.5;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        hd_o = 4'h0;
        hoe_o = 4'h0;
        flt_o = 1'b0;
    end
    task idle(input int n);
        repeat (n) begin
            #HALF;
            sck_o = 1'b1;
            #HALF;
            sck_o = 1'b0;
        end
    endtask : idle
    // One select covers the whole frame, dummy clocks included.
    task sel;
        #3.1;
        cs_n_o = 1'b0;
        #HALF;
    endtask : sel
    task desel;
        #HALF;
        cs_n_o = 1'b1;
        hoe_o = 4'h0;
        #HALF;
    endtask : desel
    // Data goes out while the clock is low and is sampled just before it rises.
    task automatic shift(input logic [31:0] v, input int nb, input int w,
                         input logic drv, output logic [31:0] r);
        logic [3:0] m;
        m = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hF;
        r = 32'h0;
        hoe_o = drv ? m : 4'h0;
        for (int i = nb; i > 0; i -= w) begin
            hd_o = 4'(v >> (i - w)) & m;
            #HALF;
            r = (r << w) | 32'(w == 1 ? {3'h0, pin_i[1]} : pin_i & m);
            sck_o = 1'b1;
            flt_o = ~flt_o;
            #HALF;
            sck_o = 1'b0;
        end
    endtask : shift
    // Double-edge nibbles, one per half clock, changed mid-phase so that
    // no clock edge races the data.
    task automatic ddr(input logic [31:0] v, input int nb, input logic drv,
                       output logic [31:0] r);
        r = 32'h0;
        hoe_o = drv ? 4'hF : 4'h0;
        for (int i = nb; i > 0; i -= 4) begin
            #(HALF / 2);
            hd_o = 4'(v >> (i - 4));
            #(HALF / 2);
            r = (r << 4) | 32'(pin_i);
            sck_o = ~sck_o;
            flt_o = ~flt_o;
        end
    endtask : ddr
endmodule : smfr_host

// ---- bench/test_smfr_read_seq.sv ----
`timescale 1ns/1ps
module test_smfr_read_seq;
    import smfr_pkg::*;
    logic clk, rstn, dual, quad, cont, fa, sck, cs_n, flt;
    logic [3:0] lat, hd, hoe, pin, dio, doe;
    logic [18:0] maddr;
    logic [7:0] mdat;
    int mismatches = 0;
    int n_tests = 0;
    function automatic logic [7:0] mem_of(input logic [18:0] a);
        return a[7:0] ^ {a[15:11], a[18:16]};
    endfunction : mem_of
    assign mdat = mem_of(maddr);
    // Undriven lines flip every serial clock so stale data cannot pass.
    assign pin = (doe & dio) | (~doe & hoe & hd) | (~doe & ~hoe & {4{flt}});
    smfr_read_seq dut_u (.clk_i(clk), .rstn_i(rstn),
        .latency_code_bits_i(lat), .dual_protocol_mode_i(dual),
        .quad_protocol_mode_i(quad), .continuous_read_mode_o(cont),
        .frame_active_o(fa), .sck_i(sck), .cs_n_i(cs_n), .io_i(pin),
        .io_o(dio), .io_oe_o(doe), .mem_addr_o(maddr), .mem_rdata_i(mdat));
    smfr_host host_u (.sck_o(sck), .cs_n_o(cs_n), .hd_o(hd), .hoe_o(hoe),
        .flt_o(flt), .pin_i(pin));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t value got %h expected %h", $time, got, exp);
        end
    endtask : check
    task results;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    task cfg(input logic d, input logic q, input logic [3:0] l);
        @(negedge clk);
        dual = d;
        quad = q;
        lat = l;
        host_u.idle(3);
    endtask : cfg
    task read_chk(input logic [7:0] opc, input logic continuous_read_mode, input int ow,
                  input int aw, input int dw, input logic [23:0] a,
                  input logic [7:0] mb, input int nby, input logic [18:0] ea);
        logic [31:0] r;
        host_u.sel();
        if (!continuous_read_mode) host_u.shift({24'h0, opc}, 8, ow, 1'b1, r);
        host_u.shift({8'h0, a}, 24, aw, 1'b1, r);
        host_u.shift({24'h0, mb}, 8, aw, 1'b1, r);
        host_u.shift(32'h0, int'(lat) * aw, aw, 1'b1, r);
        for (int k = 0; k < nby; k++) begin
            host_u.shift(32'h0, 8, dw, 1'b0, r);
            check(r[7:0], mem_of(ea + 19'(k)));
        end
        host_u.desel();
    endtask : read_chk
    task t_quick;
        cfg(1'b0, 1'b0, 4'h3);
        read_chk(8'h0B, 0, 1, 1, 1, 24'hF9_2345, 8'h00, 3, 19'h1_2345);
        cfg(1'b0, 1'b1, 4'h2);
        read_chk(8'h0B, 0, 4, 4, 4, 24'h05_5AA0, 8'h00, 2, 19'h5_5AA0);
        check({7'h0, cont}, 8'h00);
    endtask : t_quick
    task t_wrap;
        cfg(1'b1, 1'b0, 4'h1);
        read_chk(8'h0B, 0, 2, 2, 2, 24'h07_FFFE, 8'h11, 3, 19'h7_FFFE);
    endtask : t_wrap
    task t_dout_xip;
        cfg(1'b0, 1'b0, 4'h2);
        read_chk(8'h3B, 0, 1, 1, 2, 24'h00_0100, 8'hA3, 2, 19'h0_0100);
        check({7'h0, cont}, 8'h01);
        read_chk(8'h3B, 1, 1, 1, 2, 24'h03_0200, 8'h5C, 2, 19'h3_0200);
        check({7'h0, cont}, 8'h00);
        read_chk(8'h3B, 0, 1, 1, 2, 24'h00_0040, 8'h00, 1, 19'h0_0040);
    endtask : t_dout_xip
    task t_dio_xip;
        cfg(1'b0, 1'b0, 4'h0);
        read_chk(8'hBB, 0, 1, 2, 2, 24'h06_1234, 8'hAF, 2, 19'h6_1234);
        check({7'h0, cont}, 8'h01);
        read_chk(8'hBB, 1, 1, 2, 2, 24'h01_0FFF, 8'h00, 2, 19'h1_0FFF);
        check({7'h0, cont}, 8'h00);
    endtask : t_dio_xip
    task t_ddr;
        logic [31:0] r;
        cfg(1'b0, 1'b1, 4'h2);
        host_u.sel();
        host_u.shift(32'h0, 4, 4, 1'b1, r);
        host_u.ddr(32'h0D, 4, 1'b1, r);
        host_u.ddr(32'h04_3210, 24, 1'b1, r);
        host_u.ddr(32'hA4, 8, 1'b1, r);
        host_u.ddr(32'h0, 16, 1'b1, r);
        host_u.ddr(32'h0, 20, 1'b0, r);
        check(r[15:8], mem_of(19'h4_3210));
        check(r[7:0], mem_of(19'h4_3211));
        host_u.desel();
        check({7'h0, cont}, 8'h00);
    endtask : t_ddr
    task t_refuse;
        logic [31:0] r;
        cfg(1'b0, 1'b0, 4'h1);
        host_u.sel();
        host_u.shift(32'h0D, 8, 1, 1'b1, r);
        host_u.shift(32'h00_1000, 24, 1, 1'b1, r);
        host_u.shift(32'hA5, 8, 1, 1'b1, r);
        host_u.shift(32'h0, 16, 1, 1'b0, r);
        check({4'h0, doe}, 8'h00);
        host_u.desel();
        check({7'h0, cont}, 8'h00);
    endtask : t_refuse
    initial begin
        rstn = 1'b0;
        lat = 4'h0;
        dual = 1'b0;
        quad = 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        host_u.idle(3);
        t_quick();
        t_wrap();
        t_dout_xip();
        t_dio_xip();
        t_ddr();
        t_refuse();
        results();
    end
    initial begin
        #500000;
        mismatches++;
        results();
    end
endmodule : test_smfr_read_seq
